// File: status_lock_pkg.sv
// Summary of operation
// - An internal program or erase failure sets the matching error flag.
// - A program or erase aimed at a protected sector is not performed and sets its error flag.
// - On an error the error flag and the write-in-progress flag both read 1 and stay there.
// - The clear-status command clears the error flags and returns the block to standby.
// - While the status lock bit is set, writes to the block-protection fields of both status copies are ignored.
// - The status lock bit also freezes the non-volatile complement and top/bottom select bits.
// - A write-registers command with one data byte updates status register 1 only.
// - A one-byte write-registers command leaves configuration register 1 unchanged.
// - Bit 1 of the volatile configuration register is quad enable and drives the quad_enable_o output.
package status_lock_pkg;
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] CR1_RESET = 8'h00;
  localparam int SR1_WIP_BIT = 0;
  localparam int SR1_WEL_BIT = 1;
  localparam int SR1_BP_LO = 2;
  localparam int SR1_BP_HI = 5;
  localparam int SR1_TB_BIT = 6;
  localparam int CR1_LOCK_BIT = 0;
  localparam int CR1_QUAD_BIT = 1;
  localparam int CR1_CMP_BIT = 6;
  localparam int ERR_P_BIT = 6;
  localparam int ERR_E_BIT = 5;
  localparam logic [7:0] BP_FIELD_MASK = 8'h3c;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_PROGRAM = 3'b001,
    CMD_ERASE = 3'b010,
    CMD_WRITE_REGS = 3'b011,
    CMD_CLEAR_STATUS = 3'b100
  } cmd_t;

  typedef struct packed {
    logic valid;
    cmd_t cmd;
    logic target_protected;
    logic [1:0] byte_count;
    logic nonvolatile;
    logic [7:0] sr1_data;
    logic [7:0] cr1_data;
  } cmd_req_t;

  typedef struct packed {
    logic done;
    logic fail;
  } engine_result_t;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_BUSY = 2'b01,
    ST_ERROR = 2'b10
  } state_t;
endpackage

// File: reg_merge.sv
`timescale 1ns/1ps
module reg_merge (
  // Register values
  input wire logic [7:0] old_i,
  input wire logic [7:0] new_i,
  input wire logic [7:0] frozen_mask_i,
  // Merged value
  output logic [7:0] merged_o
);
  assign merged_o = (old_i & frozen_mask_i) | (new_i & ~frozen_mask_i);
endmodule

// File: status_error_and_lock_logic.sv
`timescale 1ns/1ps
module status_error_and_lock_logic (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Decoded command
  input wire status_lock_pkg::cmd_req_t req_i,
  // Program/erase engine
  input wire status_lock_pkg::engine_result_t engine_i,
  output logic engine_start_o,
  output status_lock_pkg::cmd_t engine_cmd_o,
  // Register state
  output logic [7:0] status_reg1_volatile_o,
  output logic [7:0] status_reg1_nonvolatile_o,
  output logic [7:0] config_reg1_volatile_o,
  output logic [7:0] config_reg1_nonvolatile_o,
  output logic program_error_o,
  output logic erase_error_o,
  output logic write_in_progress_flag_o,
  output logic cmd_rejected_o,
  output logic quad_enable_o
);
  status_lock_pkg::state_t state_reg, state_next;
  logic [7:0] status_reg1_volatile_reg, status_reg1_nonvolatile_reg, config_reg1_volatile_reg, config_reg1_nonvolatile_reg;
  logic p_err_reg, e_err_reg;
  status_lock_pkg::cmd_t op_reg;
  logic engine_start_reg;
  status_lock_pkg::cmd_t engine_cmd_reg;
  logic rejected_reg;

  wire is_prog = req_i.valid && req_i.cmd == status_lock_pkg::CMD_PROGRAM;
  wire is_erase = req_i.valid && req_i.cmd == status_lock_pkg::CMD_ERASE;
  wire is_wrr = req_i.valid && req_i.cmd == status_lock_pkg::CMD_WRITE_REGS;
  wire is_clr = req_i.valid && req_i.cmd == status_lock_pkg::CMD_CLEAR_STATUS;
  wire is_pe = is_prog || is_erase;
  wire in_error = state_reg == status_lock_pkg::ST_ERROR;
  wire in_standby = state_reg == status_lock_pkg::ST_STANDBY;
  wire reject = (is_pe || is_wrr) && !in_standby;
  wire prot_fail = is_pe && in_standby && req_i.target_protected;
  wire start = is_pe && in_standby && !req_i.target_protected;
  wire wrr_ok = is_wrr && in_standby;
  wire lock = config_reg1_volatile_reg[status_lock_pkg::CR1_LOCK_BIT];
  wire eng_fail = state_reg == status_lock_pkg::ST_BUSY && engine_i.done && engine_i.fail;
  wire set_p = (prot_fail && is_prog) || (eng_fail && op_reg == status_lock_pkg::CMD_PROGRAM);
  wire set_e = (prot_fail && is_erase) || (eng_fail && op_reg == status_lock_pkg::CMD_ERASE);
  wire [7:0] sr1_freeze = lock ? status_lock_pkg::BP_FIELD_MASK : 8'h00;
  wire [7:0] status_reg1_nonvolatile_freeze = sr1_freeze | (lock ? 8'h40 : 8'h00);
  wire [7:0] config_reg1_nonvolatile_freeze = lock ? 8'h40 : 8'h00;
  wire [7:0] status_reg1_volatile_merged, status_reg1_nonvolatile_merged, config_reg1_nonvolatile_merged;
  wire two_bytes = req_i.byte_count >= 2'd2;

  reg_merge u_status_reg1_volatile (.old_i(status_reg1_volatile_reg), .new_i(req_i.sr1_data), .frozen_mask_i(sr1_freeze),
                    .merged_o(status_reg1_volatile_merged));
  reg_merge u_status_reg1_nonvolatile (.old_i(status_reg1_nonvolatile_reg), .new_i(req_i.sr1_data),
                     .frozen_mask_i(status_reg1_nonvolatile_freeze), .merged_o(status_reg1_nonvolatile_merged));
  reg_merge u_config_reg1_nonvolatile (.old_i(config_reg1_nonvolatile_reg), .new_i(req_i.cr1_data),
                     .frozen_mask_i(config_reg1_nonvolatile_freeze), .merged_o(config_reg1_nonvolatile_merged));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      status_lock_pkg::ST_STANDBY: begin
        if (prot_fail) begin
          state_next = status_lock_pkg::ST_ERROR;
        end else if (start) begin
          state_next = status_lock_pkg::ST_BUSY;
        end
      end
      status_lock_pkg::ST_BUSY: begin
        if (engine_i.done) begin
          state_next = engine_i.fail ? status_lock_pkg::ST_ERROR : status_lock_pkg::ST_STANDBY;
        end
      end
      status_lock_pkg::ST_ERROR: begin
        if (is_clr) begin
          state_next = status_lock_pkg::ST_STANDBY;
        end
      end
      default: state_next = status_lock_pkg::ST_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= status_lock_pkg::ST_STANDBY;
      op_reg <= status_lock_pkg::CMD_NONE;
      p_err_reg <= 1'b0;
      e_err_reg <= 1'b0;
      engine_start_reg <= 1'b0;
      engine_cmd_reg <= status_lock_pkg::CMD_NONE;
      rejected_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      engine_start_reg <= start;
      rejected_reg <= reject;
      if (start) begin
        op_reg <= req_i.cmd;
        engine_cmd_reg <= req_i.cmd;
      end
      p_err_reg <= set_p || (p_err_reg && !is_clr);
      e_err_reg <= set_e || (e_err_reg && !is_clr);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      status_reg1_volatile_reg <= status_lock_pkg::SR1_RESET;
      status_reg1_nonvolatile_reg <= status_lock_pkg::SR1_RESET;
      config_reg1_volatile_reg <= status_lock_pkg::CR1_RESET;
      config_reg1_nonvolatile_reg <= status_lock_pkg::CR1_RESET;
    end else if (wrr_ok) begin
      if (req_i.nonvolatile) begin
        status_reg1_nonvolatile_reg <= status_reg1_nonvolatile_merged;
        if (two_bytes) begin
          config_reg1_nonvolatile_reg <= config_reg1_nonvolatile_merged;
        end
      end
      status_reg1_volatile_reg <= status_reg1_volatile_merged;
      if (two_bytes) begin
        config_reg1_volatile_reg <= req_i.cr1_data;
      end
    end
  end

  wire write_in_progress_flag = !in_standby;
  // Error flags overlay bits 6 and 5, so only bits 4:2 of the field read back
  assign status_reg1_volatile_o = {status_reg1_volatile_reg[7], p_err_reg, e_err_reg,
                                   status_reg1_volatile_reg[status_lock_pkg::SR1_BP_HI-1:status_lock_pkg::SR1_BP_LO],
                                   status_reg1_volatile_reg[status_lock_pkg::SR1_WEL_BIT], write_in_progress_flag};
  assign status_reg1_nonvolatile_o = status_reg1_nonvolatile_reg;
  assign config_reg1_volatile_o = config_reg1_volatile_reg;
  assign config_reg1_nonvolatile_o = config_reg1_nonvolatile_reg;
  assign program_error_o = p_err_reg;
  assign erase_error_o = e_err_reg;
  assign write_in_progress_flag_o = write_in_progress_flag;
  assign cmd_rejected_o = rejected_reg;
  assign engine_start_o = engine_start_reg;
  assign engine_cmd_o = engine_cmd_reg;
  // quad enable from config bit 1
  assign quad_enable_o = config_reg1_volatile_reg[status_lock_pkg::CR1_QUAD_BIT];
endmodule

// File: engine_model.sv
`timescale 1ns/1ps
module engine_model (
  // Clock, reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic start_i,
  input wire logic fail_i,
  // Result
  output status_lock_pkg::engine_result_t result_o
);
  logic [2:0] cnt_reg;
  // Fixed latency keeps checks simple
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 3'h0;
    end else if (start_i) begin
      cnt_reg <= 3'h4;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end
  assign result_o = {cnt_reg == 3'h1, fail_i};
endmodule

// File: status_error_and_lock_logic_asserts.sv
`timescale 1ns/1ps
module status_error_and_lock_logic_asserts (
  // Clock, reset, inputs
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire status_lock_pkg::cmd_req_t req_i,
  // Outputs
  input wire logic engine_start_o,
  input wire logic [7:0] status_reg1_volatile_o,
  input wire logic [7:0] status_reg1_nonvolatile_o,
  input wire logic [7:0] config_reg1_volatile_o,
  input wire logic [7:0] config_reg1_nonvolatile_o,
  input wire logic program_error_o,
  input wire logic erase_error_o,
  input wire logic write_in_progress_flag_o,
  input wire logic cmd_rejected_o,
  input wire logic quad_enable_o
);
  wire logic wp = write_in_progress_flag_o;
  wire logic go = req_i.valid && !wp;
  wire logic pg = req_i.cmd == status_lock_pkg::CMD_PROGRAM;
  wire logic wr = req_i.cmd == status_lock_pkg::CMD_WRITE_REGS;
  wire logic cl = req_i.valid && req_i.cmd == status_lock_pkg::CMD_CLEAR_STATUS;
  wire logic lk = config_reg1_volatile_o[0];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_prog_starts: assert property (go && pg && !req_i.target_protected |=> engine_start_o)
    else $error("program not started");
  a_protect_err: assert property (go && pg && req_i.target_protected |=>
    program_error_o && wp && !engine_start_o) else $error("protected program ran");
  a_err_holds: assert property (program_error_o && !cl |=> program_error_o && wp)
    else $error("error flag dropped");
  a_clear_err: assert property (cl && (program_error_o || erase_error_o) |=>
    !program_error_o && !erase_error_o) else $error("clear ignored");
  a_lock_bp: assert property (go && wr && lk |=> $stable(status_reg1_nonvolatile_o[5:2])
    && $stable(status_reg1_volatile_o[4:2])) else $error("locked field written");
  a_lock_nv: assert property (go && wr && lk |=> $stable(status_reg1_nonvolatile_o[6])
    && $stable(config_reg1_nonvolatile_o[6])) else $error("locked bit written");
  a_one_byte: assert property (go && wr && req_i.byte_count == 2'h1
    |=> $stable(config_reg1_volatile_o)) else $error("config changed");
  a_quad_bit: assert property (quad_enable_o == config_reg1_volatile_o[1])
    else $error("quad mismatch");
  a_busy_reject: assert property (req_i.valid && pg && wp |=> cmd_rejected_o)
    else $error("busy program taken");
endmodule
bind status_error_and_lock_logic status_error_and_lock_logic_asserts i_chk (.*);

// File: status_error_and_lock_logic_test.sv
`timescale 1ns/1ps
module status_error_and_lock_logic_test;
  logic clk, rst_b, fail, st, pe, ee, write_in_progress_flag, rej, qe;
  status_lock_pkg::cmd_req_t req;
  status_lock_pkg::engine_result_t eng;
  logic [7:0] sv, snv, cv, cnv, rnd, ecr, esn, ecn;
  status_lock_pkg::cmd_t ec;
  logic [2:0] ebp;
  int n_mismatch = 0;
  int n_compared = 0;
  status_error_and_lock_logic i_status_error_and_lock_logic (.core_clk_i(clk), .rst_b_i(rst_b),
    .req_i(req), .engine_i(eng), .engine_start_o(st), .engine_cmd_o(ec),
    .status_reg1_volatile_o(sv), .status_reg1_nonvolatile_o(snv),
    .config_reg1_volatile_o(cv), .config_reg1_nonvolatile_o(cnv), .program_error_o(pe),
    .erase_error_o(ee), .write_in_progress_flag_o(write_in_progress_flag), .cmd_rejected_o(rej), .quad_enable_o(qe));
  engine_model i_engine_model (.core_clk_i(clk), .rst_b_i(rst_b), .start_i(st), .fail_i(fail),
    .result_o(eng));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [2:0] exp_bp(input logic lk, input logic [2:0] o, input logic [2:0] d);
    return lk ? o : d;
  endfunction
  task automatic chk(input logic ok);
    n_compared++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: bad output", $time);
    end
  endtask
  task automatic send(input status_lock_pkg::cmd_t c, input logic p, input logic [1:0] n);
    @(posedge clk);
    #1 req.valid = 1'b1;
    req.cmd = c;
    req.target_protected = p;
    req.byte_count = n;
    @(posedge clk);
    #1 req.valid = 1'b0;
  endtask
  task automatic stop_test;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #4000 n_mismatch++;
    stop_test;
  end
  initial begin
    rst_b = 1'b0;
    fail = 1'b0;
    req = '0;
    rnd = 8'h57;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      req.nonvolatile = rnd[7];
      req.sr1_data = rnd;
      req.cr1_data = {rnd[3:0], rnd[7:4]};
      ebp = exp_bp(cv[0], sv[4:2], rnd[4:2]);
      ecr = rnd[6] ? req.cr1_data : cv;
      esn = req.nonvolatile ? (cv[0] ? {rnd[7], snv[6:2], rnd[1:0]} : rnd) : snv;
      ecn = (req.nonvolatile && rnd[6]) ?
        (cv[0] ? {req.cr1_data[7], cnv[6], req.cr1_data[5:0]} : req.cr1_data) : cnv;
      send(status_lock_pkg::CMD_WRITE_REGS, 1'b0, {rnd[6], !rnd[6]});
      chk(sv[4:2] === ebp);
      chk(snv === esn && cnv === ecn);
      chk(cv === ecr && qe === ecr[1]);
    end
    send(status_lock_pkg::CMD_PROGRAM, 1'b0, 2'h1);
    chk(st === 1'b1 && write_in_progress_flag === 1'b1 && ec === status_lock_pkg::CMD_PROGRAM);
    send(status_lock_pkg::CMD_ERASE, 1'b0, 2'h1);
    chk(rej === 1'b1);
    repeat (8) @(posedge clk);
    #1 fail = 1'b1;
    send(status_lock_pkg::CMD_PROGRAM, 1'b0, 2'h1);
    repeat (8) @(posedge clk);
    chk(pe === 1'b1 && write_in_progress_flag === 1'b1 && sv[6] === 1'b1);
    send(status_lock_pkg::CMD_WRITE_REGS, 1'b0, 2'h1);
    chk(rej === 1'b1 && pe === 1'b1);
    send(status_lock_pkg::CMD_CLEAR_STATUS, 1'b0, 2'h1);
    chk(pe === 1'b0 && write_in_progress_flag === 1'b0);
    send(status_lock_pkg::CMD_ERASE, 1'b1, 2'h1);
    chk(ee === 1'b1 && sv[5] === 1'b1 && sv[0] === 1'b1);
    send(status_lock_pkg::CMD_CLEAR_STATUS, 1'b0, 2'h1);
    chk(ee === 1'b0 && sv[0] === 1'b0);
    stop_test;
  end
endmodule
